/* pmi_consts.vh */
`ifndef PMI_CONSTS_VH
`define PMI_CONSTS_VH

// register byte offsets
`define PMI_OFS_FLAGS 8'h00
`define PMI_OFS_DISABLE 8'h10
`define PMI_OFS_LIVE 8'h20
`define PMI_OFS_CTRL 8'h30
`define PMI_OFS_GPIO_RISE 8'h34
`define PMI_OFS_GPIO_FALL 8'h38
`define PMI_OFS_LP_DELAY 8'h3c

// control register fields
`define PMI_CTRL_POL_BIT 0
`define PMI_CTRL_CLRW_BIT 1
`define PMI_CTRL_KEEP_BIT 2

// reset values
`define PMI_RST_CTRL 8'h04
`define PMI_RST_DISABLE 32'h0000_0000
`define PMI_RST_GPIO_RISE 8'hff
`define PMI_RST_GPIO_FALL 8'h00
`define PMI_RST_LP_DELAY 8'h08

// fixed edge selection, groups three..one
`define PMI_RISE_FIX 24'h87_57_70
`define PMI_FALL_FIX 24'h80_00_7a
// sources flagged only outside the off state
`define PMI_ONLY_ON 32'h0000_002a
// sources that wake when unmasked
`define PMI_WAKE_CAP 32'hff87_4300
// sources that always wake
`define PMI_WAKE_ALWAYS 32'h0000_000a
// long press source bit
`define PMI_LP_BIT 2

// power states
`define PMI_ST_OFF 2'h0

// long press time base
`define PMI_MS_NS 1000000
`define PMI_CLK_NS 25

// bus answers
`define PMI_RESP_OKAY 2'h0
`define PMI_RESP_SLVERR 2'h2

`endif

/* pmi_irq_map.v */
// Chosen here: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
// Function
// - supply monitor, group one bit 6, both edges
// - die overheat bit 5, not in off
// - power-down pin bit 4, both edges
// - remote power-on bit 3, falling, always wakes
// - long press bit 2 after delay
// - power button bit 1, falling, always wakes
// - output short group two bit 6, rising
// - external reset pin group two bit 4
// - watchdog expiry group two bit 2
// - periodic tick group two bit 1
// - calendar alarm group two bit 0
// - bus power group three bit 7, both edges
// - converter done group three bit 2
// - compare b bit 1, compare a bit 0
// - general pin n at group four bit n
// - all flags combine on one polarity-set line
// - masked source detects nothing, old flag stays
// - clear by read of group or written ones
// - repeat event held pending or discarded
`include "pmi_consts.vh"

module pmi_irq_map #(
    parameter LP_MS_CYCLES = `PMI_MS_NS / `PMI_CLK_NS // cycles per millisecond
) (
    input wire aclk,                 // system clock, 40 MHz
    input wire aresetn,              // sync reset, active low
    // axi4-lite slave
    input wire [7:0] s_axi_awaddr,   // write address
    input wire s_axi_awvalid,        // write address valid
    output wire s_axi_awready,       // write address ready
    input wire [31:0] s_axi_wdata,   // write data
    input wire [3:0] s_axi_wstrb,    // write strobes
    input wire s_axi_wvalid,         // write data valid
    output wire s_axi_wready,        // write data ready
    output wire [1:0] s_axi_bresp,   // write response
    output wire s_axi_bvalid,        // write response valid
    input wire s_axi_bready,         // write response ready
    input wire [7:0] s_axi_araddr,   // read address
    input wire s_axi_arvalid,        // read address valid
    output wire s_axi_arready,       // read address ready
    output wire [31:0] s_axi_rdata,  // read data
    output wire [1:0] s_axi_rresp,   // read response
    output wire s_axi_rvalid,        // read data valid
    input wire s_axi_rready,         // read data ready
    // event sources
    input wire supply_monitor_in,    // supply above threshold
    input wire die_overheat_in,      // die over threshold
    input wire power_down_pin,       // power-down pin
    input wire remote_power_on_pin,  // remote power-on pin
    input wire power_button_pin,     // power button, low pressed
    input wire output_short_in,      // any regulator short
    input wire external_reset_pin,   // external reset pin
    input wire watchdog_expiry_in,   // watchdog expired
    input wire periodic_tick_in,     // timer period tick
    input wire calendar_alarm_in,    // alarm match
    input wire vbus_detect_in,       // bus power present
    input wire conv_done_in,         // software conversion done
    input wire auto_conv_a_in,       // periodic compare a hit
    input wire auto_conv_b_in,       // periodic compare b hit
    input wire [7:0] gpio_pin,       // general pins
    input wire [1:0] power_state,    // 0 off, 1 sleep, 2 active
    // outputs
    output wire irq_out_line,        // combined interrupt line
    output wire on_request           // wake-up request, high
);
    // ==========================================
    // register state
    reg [31:0] flag_ff;
    reg [31:0] pend_ff;
    reg [31:0] disable_ff;
    reg [7:0] ctrl_ff;
    reg [7:0] gpio_rise_ff;
    reg [7:0] gpio_fall_ff;
    reg [7:0] lp_delay_ff;
    reg irq_line_ff;
    reg on_req_ff;
    reg wake_hold_ff;
    reg [15:0] ms_cnt_ff;
    reg [7:0] lp_cnt_ff;
    reg lp_done_ff;
    reg aw_got_ff;
    reg w_got_ff;
    reg [7:0] awaddr_ff;
    reg [7:0] wdata_ff;
    reg wstrb0_ff;
    reg bvalid_ff;
    reg [1:0] bresp_ff;
    reg rvalid_ff;
    reg [1:0] rresp_ff;
    reg [31:0] rdata_ff;

    wire [31:0] raw;
    wire [31:0] live;
    wire [31:0] edge_ev;
    wire [31:0] rise_sel;
    wire [31:0] fall_sel;

    // ==========================================
    // source vector, four groups of eight
    assign raw[7:0] = {1'b0, supply_monitor_in, die_overheat_in, power_down_pin,
                       remote_power_on_pin, power_button_pin, power_button_pin, 1'b0};
    assign raw[15:8] = {1'b0, output_short_in, 1'b0, external_reset_pin, 1'b0,
                        watchdog_expiry_in, periodic_tick_in, calendar_alarm_in};
    assign raw[23:16] = {vbus_detect_in, 4'h0, conv_done_in, auto_conv_b_in, auto_conv_a_in};
    assign raw[31:24] = gpio_pin;
    assign rise_sel = {gpio_rise_ff, `PMI_RISE_FIX};
    assign fall_sel = {gpio_fall_ff, `PMI_FALL_FIX};

    // ==========================================
    // per-source sync and edge detection
    genvar gi;
    generate
        for (gi = 0; gi < 32; gi = gi + 1) begin : g_src
            pmi_src_edge u_edge (
                .aclk(aclk),
                .aresetn(aresetn),
                .src_in(raw[gi]),
                .rise_en(rise_sel[gi]),
                .fall_en(fall_sel[gi]),
                .level(live[gi]),
                .edge_ev(edge_ev[gi])
            );
        end
    endgenerate

    // ==========================================
    // long press timer, millisecond base
    wire btn_low = ~live[1];
    wire ms_tick = (ms_cnt_ff == LP_MS_CYCLES - 1);
    wire lp_hit = btn_low & ~lp_done_ff & (lp_delay_ff != 8'h00) & (lp_cnt_ff >= lp_delay_ff);

    // count from the falling edge while held low
    always @(posedge aclk) begin
        if (!aresetn) begin
            ms_cnt_ff <= 16'h0000;
            lp_cnt_ff <= 8'h00;
            lp_done_ff <= 1'b0;
        end else if (!btn_low) begin
            ms_cnt_ff <= 16'h0000;
            lp_cnt_ff <= 8'h00;
            lp_done_ff <= 1'b0;
        end else begin
            ms_cnt_ff <= ms_tick ? 16'h0000 : ms_cnt_ff + 16'h0001;
            if (ms_tick && lp_cnt_ff != 8'hff)
                lp_cnt_ff <= lp_cnt_ff + 8'h01;
            if (lp_hit)
                lp_done_ff <= 1'b1;
        end
    end

    // ==========================================
    // event qualification
    wire in_off = (power_state == `PMI_ST_OFF);
    wire [31:0] ev_all = edge_ev | ({31'h0, lp_hit} << `PMI_LP_BIT);
    // overheat, remote power-on, button silent in off
    wire [31:0] state_ok = in_off ? ~`PMI_ONLY_ON : 32'hffff_ffff;
    // masked sources detect nothing
    wire [31:0] set_v = ev_all & ~disable_ff & state_ok;

    // ==========================================
    // axi write channel
    wire aw_hs = s_axi_awvalid & s_axi_awready;
    wire w_hs = s_axi_wvalid & s_axi_wready;
    wire ar_hs = s_axi_arvalid & s_axi_arready;
    wire wr_go = aw_got_ff & w_got_ff & ~bvalid_ff;
    wire wr_map = (awaddr_ff[7:6] == 2'h0) & (awaddr_ff[1:0] == 2'h0);
    wire wr_en = wr_go & wr_map & wstrb0_ff;
    wire [1:0] wr_grp = awaddr_ff[3:2];
    wire rd_map = (s_axi_araddr[7:6] == 2'h0) & (s_axi_araddr[1:0] == 2'h0);

    assign s_axi_awready = ~aw_got_ff & ~bvalid_ff;
    assign s_axi_wready = ~w_got_ff & ~bvalid_ff;
    assign s_axi_bvalid = bvalid_ff;
    assign s_axi_bresp = bresp_ff;
    assign s_axi_arready = ~rvalid_ff;
    assign s_axi_rvalid = rvalid_ff;
    assign s_axi_rresp = rresp_ff;
    assign s_axi_rdata = rdata_ff;

    // latch address and data, answer once both held
    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_got_ff <= 1'b0;
            w_got_ff <= 1'b0;
            awaddr_ff <= 8'h00;
            wdata_ff <= 8'h00;
            wstrb0_ff <= 1'b0;
            bvalid_ff <= 1'b0;
            bresp_ff <= `PMI_RESP_OKAY;
        end else begin
            if (aw_hs) begin
                aw_got_ff <= 1'b1;
                awaddr_ff <= s_axi_awaddr;
            end
            if (w_hs) begin
                w_got_ff <= 1'b1;
                wdata_ff <= s_axi_wdata[7:0];
                wstrb0_ff <= s_axi_wstrb[0];
            end
            if (wr_go) begin
                aw_got_ff <= 1'b0;
                w_got_ff <= 1'b0;
                bvalid_ff <= 1'b1;
                bresp_ff <= wr_map ? `PMI_RESP_OKAY : `PMI_RESP_SLVERR;
            end else if (bvalid_ff && s_axi_bready) begin
                bvalid_ff <= 1'b0;
            end
        end
    end

    // ==========================================
    // clear vectors from read and write
    wire clr_on_wr = ctrl_ff[`PMI_CTRL_CLRW_BIT];
    wire wr_flags = wr_en & (awaddr_ff[5:4] == 2'h0) & clr_on_wr;
    wire rd_flags = ar_hs & rd_map & (s_axi_araddr[5:4] == 2'h0) & ~clr_on_wr;
    wire [31:0] wr_clr = wr_flags ? ({24'h0, wdata_ff} << {wr_grp, 3'h0}) : 32'h0;
    wire [31:0] rd_clr = rd_flags ? (32'hff << {s_axi_araddr[3:2], 3'h0}) : 32'h0;
    wire [31:0] clr = wr_clr | rd_clr;

    // ==========================================
    // flags and pending level
    wire [31:0] flag_stays = flag_ff & ~(clr & ~pend_ff);
    wire keep = ctrl_ff[`PMI_CTRL_KEEP_BIT];
    wire [31:0] nxt_flag = flag_stays | set_v;
    wire [31:0] nxt_pend = (pend_ff & ~clr) | (set_v & flag_stays & {32{keep}});

    // set wins over a clear in the same cycle
    always @(posedge aclk) begin
        if (!aresetn) begin
            flag_ff <= 32'h0000_0000;
            pend_ff <= 32'h0000_0000;
        end else begin
            flag_ff <= nxt_flag;
            pend_ff <= nxt_pend;
        end
    end

    // ==========================================
    // software writable registers
    always @(posedge aclk) begin
        if (!aresetn) begin
            disable_ff <= `PMI_RST_DISABLE;
            ctrl_ff <= `PMI_RST_CTRL;
            gpio_rise_ff <= `PMI_RST_GPIO_RISE;
            gpio_fall_ff <= `PMI_RST_GPIO_FALL;
            lp_delay_ff <= `PMI_RST_LP_DELAY;
        end else if (wr_en) begin
            case ({awaddr_ff[5:4], 2'h0})
                `PMI_OFS_DISABLE >> 2: begin
                    case (wr_grp)
                        2'h0: disable_ff[7:0] <= wdata_ff;
                        2'h1: disable_ff[15:8] <= wdata_ff;
                        2'h2: disable_ff[23:16] <= wdata_ff;
                        default: disable_ff[31:24] <= wdata_ff;
                    endcase
                end
                `PMI_OFS_CTRL >> 2: begin
                    case (awaddr_ff[7:0])
                        `PMI_OFS_CTRL: ctrl_ff <= {5'h00, wdata_ff[2:0]};
                        `PMI_OFS_GPIO_RISE: gpio_rise_ff <= wdata_ff;
                        `PMI_OFS_GPIO_FALL: gpio_fall_ff <= wdata_ff;
                        `PMI_OFS_LP_DELAY: lp_delay_ff <= wdata_ff;
                        default: ctrl_ff <= ctrl_ff;
                    endcase
                end
                default: ctrl_ff <= ctrl_ff;
            endcase
        end
    end

    // ==========================================
    // read data mux
    reg [7:0] rd_byte;
    wire [1:0] rd_grp = s_axi_araddr[3:2];

    always @* begin
        rd_byte = 8'h00;
        case (s_axi_araddr[5:4])
            2'h0: rd_byte = flag_ff[{rd_grp, 3'h0} +: 8];
            2'h1: rd_byte = disable_ff[{rd_grp, 3'h0} +: 8];
            2'h2: rd_byte = live[{rd_grp, 3'h0} +: 8];
            default: begin
                case (rd_grp)
                    2'h0: rd_byte = ctrl_ff;
                    2'h1: rd_byte = gpio_rise_ff;
                    2'h2: rd_byte = gpio_fall_ff;
                    default: rd_byte = lp_delay_ff;
                endcase
            end
        endcase
    end

    // capture read answer, old flags returned before clear
    always @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_ff <= 1'b0;
            rresp_ff <= `PMI_RESP_OKAY;
            rdata_ff <= 32'h0000_0000;
        end else if (ar_hs) begin
            rvalid_ff <= 1'b1;
            rresp_ff <= rd_map ? `PMI_RESP_OKAY : `PMI_RESP_SLVERR;
            rdata_ff <= rd_map ? {24'h000000, rd_byte} : 32'h0000_0000;
        end else if (rvalid_ff && s_axi_rready) begin
            rvalid_ff <= 1'b0;
        end
    end

    // ==========================================
    // combined line and wake request
    wire any_flag = |flag_ff;
    wire pol_high = ctrl_ff[`PMI_CTRL_POL_BIT];
    // remote power-on and button wake regardless of mask
    wire always_ev = |(edge_ev & `PMI_WAKE_ALWAYS);
    wire wake_unmasked = |(flag_ff & `PMI_WAKE_CAP & ~disable_ff);

    always @(posedge aclk) begin
        if (!aresetn) begin
            irq_line_ff <= 1'b1;
            on_req_ff <= 1'b0;
            wake_hold_ff <= 1'b0;
        end else begin
            irq_line_ff <= pol_high ? any_flag : ~any_flag;
            if (always_ev)
                wake_hold_ff <= 1'b1;
            else if (!in_off && power_state[1])
                wake_hold_ff <= 1'b0;
            on_req_ff <= wake_unmasked | wake_hold_ff | always_ev;
        end
    end

    assign irq_out_line = irq_line_ff;
    assign on_request = on_req_ff;
endmodule

/* pmi_irq_map_props.sv */
`timescale 1ns/1ps
// ==========================================
// bus handshake, wake and line checks
module pmi_irq_map_props #(
    parameter LP_MS_CYCLES = 4 // cycles per ms
) (
    input wire aclk, // clock
    input wire aresetn, // sync reset
    input wire s_axi_awready, // aw ready
    input wire s_axi_bvalid, // b valid
    input wire s_axi_bready, // b ready
    input wire [1:0] s_axi_bresp, // b resp
    input wire [7:0] s_axi_araddr, // ar addr
    input wire s_axi_arvalid, // ar valid
    input wire s_axi_arready, // ar ready
    input wire [31:0] s_axi_rdata, // r data
    input wire [1:0] s_axi_rresp, // r resp
    input wire s_axi_rvalid, // r valid
    input wire s_axi_rready, // r ready
    input wire remote_power_on_pin, // remote pin
    input wire power_button_pin, // button pin
    input wire [1:0] power_state, // power state
    input wire irq_out_line, // combined line
    input wire on_request // wake request
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    a_bresp_stable: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped early");
    a_rdata_stable: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata dropped early");
    a_aw_refused: assert property (s_axi_bvalid |-> !s_axi_awready)
        else $error("aw taken during response");
    a_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("ar taken during response");
    a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    a_rd_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
        else $error("upper read bits set");
    a_rd_unmapped: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr >= 8'h40
        |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0) else $error("unmapped read okay");
    a_wake_press: assert property (($fell(remote_power_on_pin) || $fell(power_button_pin))
        && power_state == 2'h0 |-> ##[1:8] on_request) else $error("press gave no wake");
    a_line_reset: assert property (disable iff (1'b0) !aresetn |=> irq_out_line)
        else $error("line active after reset");
endmodule
bind pmi_irq_map pmi_irq_map_props #(.LP_MS_CYCLES(LP_MS_CYCLES)) chk_u (.*);

/* pmi_src_edge.v */
`timescale 1ns/1ps
// ==========================================
// source synchroniser and edge detector
module pmi_src_edge (
    input wire aclk,      // system clock
    input wire aresetn,   // sync reset, active low
    input wire src_in,    // raw source level
    input wire rise_en,   // flag rising edges
    input wire fall_en,   // flag falling edges
    output wire level,    // synchronised level
    output wire edge_ev   // one-cycle qualifying edge
);
    reg meta_ff;
    reg sync_ff;
    reg prev_ff;

    // two-stage sync then one history stage
    always @(posedge aclk) begin
        if (!aresetn) begin
            meta_ff <= 1'b0;
            sync_ff <= 1'b0;
            prev_ff <= 1'b0;
        end else begin
            meta_ff <= src_in;
            sync_ff <= meta_ff;
            prev_ff <= sync_ff;
        end
    end

    // edge qualify
    assign level = sync_ff;
    assign edge_ev = (rise_en & sync_ff & ~prev_ff) | (fall_en & ~sync_ff & prev_ff);
endmodule

/* pmi_src_model.sv */
`timescale 1ns/1ps
// ==========================================
// event source levels, toggled on request
module pmi_src_model (
    input wire aclk, // clock
    input wire [21:0] tgl, // toggle request
    output logic [21:0] src_lvl // source levels
);
    // idle: remote and button pins high
    initial src_lvl = 22'h000018;
    // change a little after the edge, unrelated to sampling
    always @(posedge aclk) begin
        src_lvl <= #3 src_lvl ^ tgl;
    end
endmodule

/* tb_pmi_irq_map.sv */
`timescale 1ns/1ps
// ==========================================
// bench for the interrupt source map
module tb_pmi_irq_map;
    logic aclk = 0, aresetn = 0;
    logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [31:0] s_axi_wdata = 0;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic s_axi_arvalid = 0, s_axi_rready = 0;
    logic [1:0] power_state = 2'h2;
    logic [21:0] tgl = 0;
    wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire irq_out_line, on_request;
    wire [1:0] s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata;
    wire supply_monitor_in, die_overheat_in, power_down_pin, remote_power_on_pin;
    wire power_button_pin, output_short_in, external_reset_pin, watchdog_expiry_in;
    wire periodic_tick_in, calendar_alarm_in, vbus_detect_in, conv_done_in;
    wire auto_conv_a_in, auto_conv_b_in;
    wire [7:0] gpio_pin;
    wire [21:0] src_lvl;
    int miscompares = 0, cmp_count = 0;
    int fb [22] = '{6, 5, 4, 3, 1, 14, 12, 10, 9, 8, 23, 18, 16, 17,
        24, 25, 26, 27, 28, 29, 30, 31};
    logic [21:0] both = 22'h000407;
    logic [1:0] last_bresp = 2'h0;
    // source vector to pins
    assign {gpio_pin, auto_conv_b_in, auto_conv_a_in, conv_done_in, vbus_detect_in,
        calendar_alarm_in, periodic_tick_in, watchdog_expiry_in, external_reset_pin,
        output_short_in, power_button_pin, remote_power_on_pin, power_down_pin,
        die_overheat_in, supply_monitor_in} = src_lvl;
    pmi_irq_map #(.LP_MS_CYCLES(4)) dut_u (.*);
    pmi_src_model src_u (.aclk(aclk), .tgl(tgl), .src_lvl(src_lvl));
    // 40 MHz clock
    always #12.5 aclk = ~aclk;
    task test_done;
        begin
            $display("checks %0d mismatches %0d", cmp_count, miscompares);
            if (miscompares == 0 && cmp_count > 0) $display("Run complete: PASS");
            else $display("Run complete: FAIL");
            $finish;
        end
    endtask
    task tmo;
        begin
            miscompares++;
            test_done();
        end
    endtask
    task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        begin
            cmp_count++;
            if (s !== e) begin
                miscompares++;
                $display("ERROR %s exp %h seen %h", nm, e, s);
            end
        end
    endtask
    task axi_wr(input logic [7:0] a, input logic [31:0] d);
        int n;
        logic ta, tw, tv, dn;
        begin
            dn = 0;
            @(posedge aclk);
            s_axi_awaddr <= a;
            s_axi_wdata <= d;
            {s_axi_awvalid, s_axi_wvalid} <= 2'b11;
            for (n = 0; n < 60 && !dn; n++) begin
                @(negedge aclk);
                ta = s_axi_awvalid && s_axi_awready;
                tw = s_axi_wvalid && s_axi_wready;
                dn = s_axi_bvalid && s_axi_bready;
                tv = s_axi_bvalid;
                if (dn) last_bresp = s_axi_bresp;
                @(posedge aclk);
                if (ta) s_axi_awvalid <= 1'b0;
                if (tw) s_axi_wvalid <= 1'b0;
                s_axi_bready <= tv && !dn;
            end
            if (!dn) tmo();
        end
    endtask
    task axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        logic ta, tv, dn;
        begin
            dn = 0;
            @(posedge aclk);
            s_axi_araddr <= a;
            s_axi_arvalid <= 1'b1;
            for (n = 0; n < 60 && !dn; n++) begin
                @(negedge aclk);
                ta = s_axi_arvalid && s_axi_arready;
                dn = s_axi_rvalid && s_axi_rready;
                tv = s_axi_rvalid;
                d = s_axi_rdata;
                r = s_axi_rresp;
                @(posedge aclk);
                if (ta) s_axi_arvalid <= 1'b0;
                s_axi_rready <= tv && !dn;
            end
            if (!dn) tmo();
        end
    endtask
    task rd_chk(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] d;
        logic [1:0] r;
        begin
            axi_rd(a, d, r);
            chk("rdata", d, e);
        end
    endtask
    // toggle sources, then let the event settle
    task flip(input logic [21:0] b, input int n);
        repeat (n) begin
            @(posedge aclk);
            tgl <= b;
            @(posedge aclk);
            tgl <= 22'h0;
            repeat (8) @(posedge aclk);
        end
    endtask
    task sc_reset;
        logic [31:0] d;
        logic [1:0] r;
        begin
            rd_chk(8'h30, 32'h04);
            rd_chk(8'h34, 32'hff);
            rd_chk(8'h3c, 32'h08);
            rd_chk(8'h10, 32'h00);
            axi_rd(8'h40, d, r);
            chk("rresp", r, 32'h2);
            axi_wr(8'h40, 32'h0);
            chk("bresp", last_bresp, 32'h2);
            // live levels: remote and button pins idle high
            rd_chk(8'h20, 32'h0e);
            chk("irq", irq_out_line, 32'h1);
        end
    endtask
    task sc_map;
        logic [31:0] e;
        int i;
        begin
            for (i = 0; i < 22; i++) begin
                e = 32'h1 << (fb[i] % 8);
                flip(22'h1 << i, 1);
                rd_chk(8'(fb[i] / 8 * 4), e);
                flip(22'h1 << i, 1);
                rd_chk(8'(fb[i] / 8 * 4), both[i] ? e : 32'h0);
            end
            axi_wr(8'h38, 32'h1);
            axi_wr(8'h34, 32'h0);
            flip(22'h1 << 14, 1);
            rd_chk(8'h0c, 32'h0);
            flip(22'h1 << 14, 1);
            rd_chk(8'h0c, 32'h1);
            axi_wr(8'h34, 32'hff);
            axi_wr(8'h38, 32'h0);
        end
    endtask
    task sc_state;
        begin
            @(posedge aclk);
            power_state <= 2'h0;
            flip(22'h1a, 1);
            rd_chk(8'h00, 32'h0);
            chk("wake", on_request, 32'h1);
            flip(22'h1a, 1);
            power_state <= 2'h2;
            repeat (4) @(posedge aclk);
            chk("wake", on_request, 32'h0);
        end
    endtask
    task sc_mask;
        begin
            axi_wr(8'h14, 32'h04);
            flip(22'h80, 2);
            rd_chk(8'h04, 32'h0);
            axi_wr(8'h14, 32'h0);
            flip(22'h80, 1);
            axi_wr(8'h14, 32'h04);
            rd_chk(8'h04, 32'h04);
            flip(22'h80, 1);
            axi_wr(8'h14, 32'h0);
        end
    endtask
    task sc_clrw;
        begin
            axi_wr(8'h30, 32'h02);
            flip(22'h280, 1);
            chk("irq", irq_out_line, 32'h0);
            axi_wr(8'h04, 32'h01);
            rd_chk(8'h04, 32'h04);
            axi_wr(8'h04, 32'hff);
            rd_chk(8'h04, 32'h0);
            chk("irq", irq_out_line, 32'h1);
            flip(22'h280, 1);
            axi_wr(8'h30, 32'h07);
            chk("irq", irq_out_line, 32'h0);
            axi_wr(8'h30, 32'h04);
        end
    endtask
    task sc_pend;
        begin
            flip(22'h80, 3);
            rd_chk(8'h04, 32'h04);
            rd_chk(8'h00, 32'h0);
            rd_chk(8'h04, 32'h04);
            rd_chk(8'h04, 32'h0);
            axi_wr(8'h30, 32'h0);
            flip(22'h80, 4);
            rd_chk(8'h04, 32'h04);
            rd_chk(8'h04, 32'h0);
            flip(22'h80, 1);
            axi_wr(8'h30, 32'h04);
        end
    endtask
    task sc_long;
        begin
            axi_wr(8'h3c, 32'h02);
            flip(22'h10, 1);
            repeat (20) @(posedge aclk);
            rd_chk(8'h00, 32'h06);
            // shorter delay first, then a longer one so the second press stays short
            axi_wr(8'h3c, 32'h08);
            flip(22'h10, 2);
            rd_chk(8'h00, 32'h02);
        end
    endtask
    initial begin
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        sc_reset();
        sc_map();
        sc_state();
        sc_mask();
        sc_clrw();
        sc_pend();
        sc_long();
        test_done();
    end
endmodule
